/* logic/swc_pkg.sv */
`default_nettype none

package swc_pkg;

    // ---------------------------------------------------------------
    // register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_HI   = 8'h80;
    localparam logic [7:0] ADDR_CTRL_LO   = 8'h81;
    localparam logic [7:0] ADDR_START_HI  = 8'h82;
    localparam logic [7:0] ADDR_START_MID = 8'h83;
    localparam logic [7:0] ADDR_START_LO  = 8'h84;
    localparam logic [7:0] ADDR_INCR_HI   = 8'h85;
    localparam logic [7:0] ADDR_INCR_MID  = 8'h86;
    localparam logic [7:0] ADDR_INCR_LO   = 8'h87;
    localparam logic [7:0] ADDR_NUM_HI    = 8'h88;
    localparam logic [7:0] ADDR_NUM_LO    = 8'h89;
    localparam logic [7:0] ADDR_SETTLE_HI = 8'h8A;
    localparam logic [7:0] ADDR_SETTLE_LO = 8'h8B;
    localparam logic [7:0] ADDR_STATUS    = 8'h8F;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] CTRL_RESET     = 16'hA000;
    localparam int          CMD_LSB        = 4;
    localparam int          RANGE_LSB      = 1;
    localparam int          GAIN_BIT       = 0;
    localparam int          RESET_BIT      = 4;
    localparam int          STAT_VALID_BIT = 1;
    localparam int          STAT_DONE_BIT  = 2;
    localparam logic [1:0]  MULT_X2        = 2'h1;
    localparam logic [1:0]  MULT_X4        = 2'h3;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP     = 4'h0,
        CMD_INIT    = 4'h1,
        CMD_SWEEP   = 4'h2,
        CMD_INCR    = 4'h3,
        CMD_REPEAT  = 4'h4,
        CMD_PDOWN   = 4'hA,
        CMD_STANDBY = 4'hB
    } swc_cmd_e;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_EXCITE  = 5'h02,
        ST_SETTLE  = 5'h04,
        ST_CONVERT = 5'h08,
        ST_HOLD    = 5'h10
    } swc_state_e;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } swc_reg_wr_s;

    typedef struct packed {
        logic sweep_done;
        logic valid;
    } swc_status_s;

    // settling cycles after the multiplier; reserved code counts as x1
    function automatic logic [10:0] settle_total(input logic [8:0] n, input logic [1:0] m);
        logic [10:0] r;
        r = {2'h0, n};
        if (m == MULT_X2) begin
            r = {1'h0, n, 1'h0};
        end else if (m == MULT_X4) begin
            r = {n, 2'h0};
        end
        return r;
    endfunction

endpackage

`default_nettype wire

/* logic/swc_settle_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module swc_settle_timer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic        cycle_tick,
    input  wire logic [8:0]  cycles,
    input  wire logic [1:0]  mult,
    output logic             done
);
    logic [10:0] remain;
    logic        running;
    wire  logic  last_tick = running && (remain == 11'h000 || (remain == 11'h001 && cycle_tick));

    // ---------------------------------------------------------------
    // counts excitation cycles, pulses done when all have passed
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            remain  <= 11'h000;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                remain  <= swc_pkg::settle_total(cycles, mult);
                running <= 1'b1;
            end else if (last_tick) begin
                running <= 1'b0;
                done    <= 1'b1;
            end else if (running && cycle_tick) begin
                remain <= remain - 11'h001;
            end
        end
    end

    a_done_needs_run : assert property (@(posedge clock) disable iff (rst)
        done |-> $past(running) && !running) else $error("settle done without a running count"); // R4

endmodule // swc_settle_timer

`default_nettype wire

/* logic/swc_freq_stepper.sv */
`timescale 1ns/1ps
`default_nettype none

module swc_freq_stepper #(
    parameter int FREQ_W = 24,
    parameter int IDX_W  = 9
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              load,
    input  wire logic              step,
    input  wire logic [FREQ_W-1:0] start_freq,
    input  wire logic [FREQ_W-1:0] incr_freq,
    output logic      [FREQ_W-1:0] freq,
    output logic      [IDX_W-1:0]  index
);
    // ---------------------------------------------------------------
    // current frequency point and its position in the sweep
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            freq  <= '0;
            index <= '0;
        end else if (load) begin
            freq  <= start_freq;
            index <= '0;
        end else if (step) begin
            freq  <= freq + incr_freq;
            index <= index + IDX_W'(1);
        end
    end

    a_step_adds : assert property (@(posedge clock) disable iff (rst)
        step && !load |=> freq == $past(freq) + $past(incr_freq)) else $error("step did not add increment"); // R5

endmodule // swc_freq_stepper

`default_nettype wire

/* logic/swc_sweep_control.sv */
`timescale 1ns/1ps
`default_nettype none

//
// Behaviour
// R1: upper control nibble decodes to seven commands; other codes do nothing
// R2: initialize drives excitation at start frequency until another command
// R3: host waits its own settling time before issuing start-sweep
// R4: start-sweep converts only after the programmed settling cycles
// R5: increment steps to the next point, then settles before converting
// R6: host increments only after reading the previous point's result
// R7: repeat measures the same point again without changing frequency
// R8: comes up in power-down with control register at its default
// R9: power-down grounds both excitation and response pins
// R10: standby powers up but keeps both pins grounded
// R11: reset aborts the sweep and keeps frequency and point registers
// R12: after reset, initialize is needed before sweeping again
// R13: control field selects the excitation voltage range
// R14: control bit selects response gain of one or five
// R15: valid flag clears on sweep, increment, repeat, reset and power-up; a conversion ending in the same cycle as a command sets it instead
// R16: sweep-complete flag sets when every programmed increment is measured
// R17: commands act on upper control byte writes; no-op changes nothing
//
module swc_sweep_control (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire swc_pkg::swc_reg_wr_s reg_wr,
    input  wire logic [7:0]           reg_rd_addr,
    input  wire logic                 cycle_tick,
    input  wire logic                 conv_done,
    output logic [7:0]                reg_rdata,
    output logic [23:0]               excitation_freq,
    output logic                      excitation_enable,
    output logic                      excitation_output_pin_gnd,
    output logic                      response_input_pin_gnd,
    output logic                      analog_power_on,
    output logic                      conv_start,
    output logic [1:0]                output_range,
    output logic                      pga_gain_x1,
    output swc_pkg::swc_status_s      status
);
    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    logic [7:0]          ctrl_hi;
    logic [7:0]          ctrl_lo;
    logic [23:0]         start_freq;
    logic [23:0]         incr_freq;
    logic [8:0]          num_incr;
    logic [10:0]         settle_cfg;
    logic                powered_down;
    swc_pkg::swc_state_e state;
    swc_pkg::swc_state_e next_state;
    logic [8:0]          point_index;
    logic                settle_done;

    // ---------------------------------------------------------------
    // write decode
    // ---------------------------------------------------------------
    wire logic wr_hi     = reg_wr.en && reg_wr.addr == swc_pkg::ADDR_CTRL_HI;
    wire logic wr_lo     = reg_wr.en && reg_wr.addr == swc_pkg::ADDR_CTRL_LO;
    wire logic [3:0] cmd = reg_wr.data[swc_pkg::CMD_LSB +: 4];
    wire logic active    = state != swc_pkg::ST_IDLE;
    wire logic do_init   = wr_hi && cmd == swc_pkg::CMD_INIT; // R1 R17
    wire logic do_sweep  = wr_hi && cmd == swc_pkg::CMD_SWEEP && active; // R1 R12
    wire logic do_repeat = wr_hi && cmd == swc_pkg::CMD_REPEAT && active; // R1 R7
    wire logic do_incr   = wr_hi && cmd == swc_pkg::CMD_INCR && active && point_index < num_incr; // R1 R5
    wire logic do_pdown  = wr_hi && cmd == swc_pkg::CMD_PDOWN; // R1
    wire logic do_stby   = wr_hi && cmd == swc_pkg::CMD_STANDBY; // R1
    wire logic do_reset  = wr_lo && reg_wr.data[swc_pkg::RESET_BIT]; // R11
    wire logic do_settle = do_sweep || do_repeat || do_incr;
    wire logic do_abort  = do_init || do_pdown || do_stby || do_reset;
    wire logic conv_end  = state == swc_pkg::ST_CONVERT && conv_done;
    wire logic last_pt   = point_index >= num_incr;

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_hi    <= swc_pkg::CTRL_RESET[15:8]; // R8
            ctrl_lo    <= swc_pkg::CTRL_RESET[7:0]; // R8
            start_freq <= '0;
            incr_freq  <= '0;
            num_incr   <= '0;
            settle_cfg <= '0;
        end else if (reg_wr.en) begin
            case (reg_wr.addr)
                swc_pkg::ADDR_CTRL_HI:   ctrl_hi <= reg_wr.data;
                swc_pkg::ADDR_CTRL_LO:   ctrl_lo <= reg_wr.data & ~(8'h01 << swc_pkg::RESET_BIT);
                swc_pkg::ADDR_START_HI:  start_freq[23:16] <= reg_wr.data;
                swc_pkg::ADDR_START_MID: start_freq[15:8] <= reg_wr.data;
                swc_pkg::ADDR_START_LO:  start_freq[7:0] <= reg_wr.data;
                swc_pkg::ADDR_INCR_HI:   incr_freq[23:16] <= reg_wr.data;
                swc_pkg::ADDR_INCR_MID:  incr_freq[15:8] <= reg_wr.data;
                swc_pkg::ADDR_INCR_LO:   incr_freq[7:0] <= reg_wr.data;
                swc_pkg::ADDR_NUM_HI:    num_incr[8] <= reg_wr.data[0];
                swc_pkg::ADDR_NUM_LO:    num_incr[7:0] <= reg_wr.data;
                swc_pkg::ADDR_SETTLE_HI: settle_cfg[10:8] <= reg_wr.data[2:0];
                swc_pkg::ADDR_SETTLE_LO: settle_cfg[7:0] <= reg_wr.data;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_rd_addr)
            swc_pkg::ADDR_CTRL_HI:   rd_mux = ctrl_hi;
            swc_pkg::ADDR_CTRL_LO:   rd_mux = ctrl_lo;
            swc_pkg::ADDR_START_HI:  rd_mux = start_freq[23:16];
            swc_pkg::ADDR_START_MID: rd_mux = start_freq[15:8];
            swc_pkg::ADDR_START_LO:  rd_mux = start_freq[7:0];
            swc_pkg::ADDR_INCR_HI:   rd_mux = incr_freq[23:16];
            swc_pkg::ADDR_INCR_MID:  rd_mux = incr_freq[15:8];
            swc_pkg::ADDR_INCR_LO:   rd_mux = incr_freq[7:0];
            swc_pkg::ADDR_NUM_HI:    rd_mux = {7'h00, num_incr[8]};
            swc_pkg::ADDR_NUM_LO:    rd_mux = num_incr[7:0];
            swc_pkg::ADDR_SETTLE_HI: rd_mux = {5'h00, settle_cfg[10:8]};
            swc_pkg::ADDR_SETTLE_LO: rd_mux = settle_cfg[7:0];
            swc_pkg::ADDR_STATUS:    rd_mux = {5'h00, status.sweep_done, status.valid, 1'b0};
            default:                 rd_mux = 8'h00;
        endcase
    end

    // ---------------------------------------------------------------
    // sweep sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            swc_pkg::ST_IDLE:    next_state = state;
            swc_pkg::ST_EXCITE:  next_state = state; // R2
            swc_pkg::ST_SETTLE:  if (settle_done) begin
                next_state = swc_pkg::ST_CONVERT; // R4 R5
            end
            swc_pkg::ST_CONVERT: if (conv_done) begin
                next_state = swc_pkg::ST_HOLD;
            end
            swc_pkg::ST_HOLD:    next_state = state;
            default:             next_state = swc_pkg::ST_IDLE;
        endcase
        if (do_settle) begin
            next_state = swc_pkg::ST_SETTLE; // R4 R5 R7
        end
        if (do_init) begin
            next_state = swc_pkg::ST_EXCITE; // R2
        end
        if (do_pdown || do_stby || do_reset) begin
            next_state = swc_pkg::ST_IDLE; // R9 R10 R11 R12
        end
    end

    wire logic next_power_down = do_pdown ? 1'b1 : (do_init || do_stby) ? 1'b0 : powered_down; // R9 R10
    wire logic next_valid = conv_end ? 1'b1 : (do_settle || do_reset) ? 1'b0 : status.valid; // R15
    wire logic next_done  = (conv_end && last_pt) ? 1'b1 : do_reset ? 1'b0 : status.sweep_done; // R16 R11

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state                     <= swc_pkg::ST_IDLE;
            powered_down              <= 1'b1; // R8
            status                    <= '0; // R15
            conv_start                <= 1'b0;
            excitation_enable         <= 1'b0;
            excitation_output_pin_gnd <= 1'b1;
            response_input_pin_gnd    <= 1'b1;
            analog_power_on           <= 1'b0;
            reg_rdata                 <= 8'h00;
        end else begin
            state                     <= next_state;
            powered_down              <= next_power_down;
            status.valid              <= next_valid;
            status.sweep_done         <= next_done;
            conv_start                <= state == swc_pkg::ST_SETTLE && settle_done && !do_abort && !do_settle;
            excitation_enable         <= next_state != swc_pkg::ST_IDLE;
            excitation_output_pin_gnd <= next_state == swc_pkg::ST_IDLE; // R9 R10
            response_input_pin_gnd    <= next_state == swc_pkg::ST_IDLE; // R9 R10
            analog_power_on           <= !next_power_down; // R10
            reg_rdata                 <= rd_mux;
        end
    end

    assign output_range = ctrl_hi[swc_pkg::RANGE_LSB +: 2]; // R13
    assign pga_gain_x1  = ctrl_hi[swc_pkg::GAIN_BIT]; // R14

    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    swc_settle_timer swc_settle_timer_i (
        .clock      (clock),
        .rst        (rst),
        .start      (do_settle),
        .abort      (do_abort),
        .cycle_tick (cycle_tick),
        .cycles     (settle_cfg[8:0]),
        .mult       (settle_cfg[10:9]),
        .done       (settle_done)
    );

    swc_freq_stepper #(
        .FREQ_W (24),
        .IDX_W  (9)
    ) swc_freq_stepper_i (
        .clock      (clock),
        .rst        (rst),
        .load       (do_init), // R2
        .step       (do_incr), // R5
        .start_freq (start_freq),
        .incr_freq  (incr_freq),
        .freq       (excitation_freq),
        .index      (point_index)
    );

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_nop_holds_state : assert property (@(posedge clock) disable iff (rst) // R17
        wr_hi && !reg_wr.data[7] && cmd == swc_pkg::CMD_NOP && state != swc_pkg::ST_SETTLE
            && state != swc_pkg::ST_CONVERT |=> $stable(state) && $stable(excitation_freq))
        else $error("no-op changed sweep state");

    a_init_excites : assert property (@(posedge clock) disable iff (rst) // R2
        do_init |=> state == swc_pkg::ST_EXCITE ##1 excitation_freq == $past(start_freq, 2)
            && excitation_enable && !excitation_output_pin_gnd)
        else $error("initialize did not drive start frequency");

    a_settle_before_conv : assert property (@(posedge clock) disable iff (rst) // R4
        conv_start |-> $past(state) == swc_pkg::ST_SETTLE && $past(settle_done))
        else $error("conversion started before settling");

    a_sweep_needs_init : assert property (@(posedge clock) disable iff (rst) // R12
        wr_hi && cmd == swc_pkg::CMD_SWEEP && state == swc_pkg::ST_IDLE |=> state == swc_pkg::ST_IDLE)
        else $error("sweep started without initialize");

    a_repeat_keeps_freq : assert property (@(posedge clock) disable iff (rst) // R7
        do_repeat |=> $stable(excitation_freq) && state == swc_pkg::ST_SETTLE)
        else $error("repeat changed frequency");

    a_pins_grounded : assert property (@(posedge clock) disable iff (rst) // R9 R10
        state == swc_pkg::ST_IDLE |-> excitation_output_pin_gnd && response_input_pin_gnd)
        else $error("pins not grounded while idle");

    a_reset_keeps_regs : assert property (@(posedge clock) disable iff (rst) // R11
        do_reset && !conv_end |=> $stable(start_freq) && $stable(incr_freq) && $stable(num_incr)
            && state == swc_pkg::ST_IDLE && !status.valid && !status.sweep_done)
        else $error("reset command disturbed sweep registers");

    a_valid_clears : assert property (@(posedge clock) disable iff (rst) // R15
        do_settle && !conv_end |=> !status.valid)
        else $error("valid flag not cleared by command");

    a_done_on_last : assert property (@(posedge clock) disable iff (rst) // R16
        conv_end && last_pt && !do_abort && !do_settle |=> status.sweep_done && status.valid
            && state == swc_pkg::ST_HOLD)
        else $error("sweep complete not set on last point");

    a_pdown_power : assert property (@(posedge clock) disable iff (rst) // R9
        do_pdown |=> powered_down ##1 !analog_power_on)
        else $error("power-down did not remove power");

    a_incr_steps : assert property (@(posedge clock) disable iff (rst) // R5
        do_incr |=> excitation_freq == $past(excitation_freq) + $past(incr_freq) && state == swc_pkg::ST_SETTLE)
        else $error("increment did not step the frequency");

    a_standby_pins : assert property (@(posedge clock) disable iff (rst) // R10
        do_stby |=> analog_power_on && excitation_output_pin_gnd && response_input_pin_gnd)
        else $error("standby did not power up with pins grounded");

    a_init_powers : assert property (@(posedge clock) disable iff (rst) // R2
        do_init |=> analog_power_on && !response_input_pin_gnd)
        else $error("initialize left the analog side off");

    a_valid_from_conv : assert property (@(posedge clock) disable iff (rst) // R4
        $rose(status.valid) |-> $past(conv_end))
        else $error("valid set without a finished conversion");

    a_range_gain : assert property (@(posedge clock) disable iff (rst) // R13 R14
        wr_hi |=> {output_range, pga_gain_x1} == $past(reg_wr.data[2:0]))
        else $error("range or gain field not taken from control write");

    a_done_sticky : assert property (@(posedge clock) disable iff (rst) // R16
        status.sweep_done && !do_reset |=> status.sweep_done)
        else $error("sweep complete dropped without reset");

    c_full_point : cover property (@(posedge clock) disable iff (rst)
        do_sweep ##[1:300] conv_start ##[1:300] status.valid);
    c_last_point : cover property (@(posedge clock) disable iff (rst)
        do_incr ##[1:600] status.sweep_done);
    c_repeat : cover property (@(posedge clock) disable iff (rst)
        status.valid ##1 do_repeat);
    c_reset_abort : cover property (@(posedge clock) disable iff (rst)
        state == swc_pkg::ST_SETTLE && do_reset);
    c_refused_incr : cover property (@(posedge clock) disable iff (rst)
        wr_hi && cmd == swc_pkg::CMD_INCR && active && !do_incr);

endmodule // swc_sweep_control

`default_nettype wire

/* dv/swc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// synthesiser ticks and converter behind the control block
// ---------------------------------------------------------------
module swc_analog_model #(
    parameter int TICK_DIV = 3,
    parameter int CONV_LAT = 5
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic conv_start,
    output logic      cycle_tick,
    output logic      conv_done
);
    int div_q;
    int lat_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q <= 0;
            lat_q <= 0;
            cycle_tick <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            cycle_tick <= (div_q == 0);
            lat_q <= conv_start ? CONV_LAT : ((lat_q > 0) ? lat_q - 1 : 0);
            conv_done <= (lat_q == 1);
        end
    end
endmodule // swc_analog_model

`default_nettype wire

/* dv/swc_sweep_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module swc_sweep_control_tb_top;
    localparam logic [23:0] START = 24'h3D70A3;
    localparam logic [23:0] INCR  = 24'h00053E;
    logic                 clock       = 1'b0;
    logic                 rst         = 1'b1;
    swc_pkg::swc_reg_wr_s reg_wr      = '0;
    logic [7:0]           reg_rd_addr = 8'h00;
    wire logic            cycle_tick;
    wire logic            conv_done;
    logic [7:0]           reg_rdata;
    logic [23:0]          excitation_freq;
    logic                 excitation_enable;
    logic                 out_gnd;
    logic                 in_gnd;
    logic                 analog_power_on;
    logic                 conv_start;
    logic [1:0]           output_range;
    logic                 pga_gain_x1;
    swc_pkg::swc_status_s status;
    int                   fail_count  = 0;
    int                   check_count = 0;

    always #5 clock = ~clock;

    swc_sweep_control swc_sweep_control_i (.clock(clock), .rst(rst), .reg_wr(reg_wr),
        .reg_rd_addr(reg_rd_addr), .cycle_tick(cycle_tick), .conv_done(conv_done), .reg_rdata(reg_rdata),
        .excitation_freq(excitation_freq), .excitation_enable(excitation_enable),
        .excitation_output_pin_gnd(out_gnd), .response_input_pin_gnd(in_gnd),
        .analog_power_on(analog_power_on), .conv_start(conv_start), .output_range(output_range),
        .pga_gain_x1(pga_gain_x1), .status(status));
    swc_analog_model swc_analog_model_i (.clock(clock), .rst(rst), .conv_start(conv_start),
        .cycle_tick(cycle_tick), .conv_done(conv_done));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr <= '{en: 1'b1, addr: a, data: d};
        @(negedge clock);
        reg_wr.en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_rd_addr <= a;
        @(negedge clock);
        chk(reg_rdata, exp);
    endtask

    // issue a measuring command, count settling ticks, wait for the result
    task automatic measure(input logic [7:0] cmd);
        int ticks;
        ticks = 0;
        wr(swc_pkg::ADDR_CTRL_HI, cmd);
        chk(status.valid, 1'b0);
        for (int i = 0; i < 100 && conv_start !== 1'b1; i++) begin
            ticks += (cycle_tick === 1'b1);
            @(negedge clock);
        end
        chk(ticks, 4);
        for (int i = 0; i < 20 && status.valid !== 1'b1; i++) @(negedge clock);
        chk(status.valid, 1'b1);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_power_up();
        chk({out_gnd, in_gnd, analog_power_on, excitation_enable, status}, 6'h30);
        rd(swc_pkg::ADDR_CTRL_HI, 8'hA0);
        rd(8'h90, 8'h00);
    endtask

    task automatic t_init();
        wr(swc_pkg::ADDR_START_HI, START[23:16]);
        wr(swc_pkg::ADDR_START_MID, START[15:8]);
        wr(swc_pkg::ADDR_START_LO, START[7:0]);
        wr(swc_pkg::ADDR_INCR_HI, INCR[23:16]);
        wr(swc_pkg::ADDR_INCR_MID, INCR[15:8]);
        wr(swc_pkg::ADDR_INCR_LO, INCR[7:0]);
        wr(swc_pkg::ADDR_NUM_LO, 8'h01);
        wr(swc_pkg::ADDR_SETTLE_HI, 8'h02);
        wr(swc_pkg::ADDR_SETTLE_LO, 8'h02);
        wr(swc_pkg::ADDR_CTRL_HI, 8'h10);
        repeat (30) @(negedge clock);
        chk({excitation_enable, out_gnd, in_gnd, analog_power_on}, 4'h9);
        chk(excitation_freq, START);
    endtask

    task automatic t_sweep_points();
        measure(8'h20);
        chk(status.sweep_done, 1'b0);
        rd(swc_pkg::ADDR_STATUS, 8'h02);
        measure(8'h30);
        chk(excitation_freq, START + INCR);
        chk(status.sweep_done, 1'b1);
        measure(8'h40);
        chk(excitation_freq, START + INCR);
    endtask

    task automatic t_nop_fields();
        wr(swc_pkg::ADDR_CTRL_HI, 8'h30);
        for (int c = 5; c < 16; c++) begin
            if (c != 10 && c != 11) begin
                wr(swc_pkg::ADDR_CTRL_HI, 8'(c << 4) | 8'h07);
                chk({excitation_enable, analog_power_on, status.valid}, 3'h7);
            end
        end
        chk(excitation_freq, START + INCR);
        chk({output_range, pga_gain_x1}, 3'h7);
        wr(swc_pkg::ADDR_CTRL_HI, 8'h02);
        chk({output_range, pga_gain_x1}, 3'h2);
    endtask

    task automatic t_reset_cmd();
        wr(swc_pkg::ADDR_CTRL_LO, 8'h10);
        chk({excitation_enable, out_gnd, status}, 4'h4);
        rd(swc_pkg::ADDR_START_HI, START[23:16]);
        rd(swc_pkg::ADDR_INCR_LO, INCR[7:0]);
        rd(swc_pkg::ADDR_NUM_LO, 8'h01);
        wr(swc_pkg::ADDR_CTRL_HI, 8'h20);
        repeat (30) @(negedge clock);
        chk({excitation_enable, status.valid}, 2'h0);
        wr(swc_pkg::ADDR_SETTLE_HI, 8'h06);
        wr(swc_pkg::ADDR_SETTLE_LO, 8'h01);
        wr(swc_pkg::ADDR_CTRL_HI, 8'h10);
        repeat (5) @(negedge clock);
        chk(excitation_freq, START);
        measure(8'h20);
    endtask

    task automatic t_power_modes();
        wr(swc_pkg::ADDR_CTRL_HI, 8'hB0);
        chk({analog_power_on, out_gnd, in_gnd}, 3'h7);
        rd(swc_pkg::ADDR_CTRL_HI, 8'hB0);
        wr(swc_pkg::ADDR_CTRL_HI, 8'hA0);
        chk({analog_power_on, out_gnd, in_gnd}, 3'h3);
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst <= 1'b0;
        @(negedge clock);
        t_power_up();
        t_init();
        t_sweep_points();
        t_nop_fields();
        t_reset_cmd();
        t_power_modes();
        give_verdict();
    end

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule // swc_sweep_control_tb_top

`default_nettype wire
